/* verilog/e1_perf_counters.sv */
// Local design decision: register access over AXI4-Lite.
module e1_perf_counters #(
   parameter int LONG_CYCLES = e1_perf_pkg::LONG_INTERVAL_CYCLES,
   parameter int SHORT_CYCLES = e1_perf_pkg::SHORT_INTERVAL_CYCLES
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [e1_perf_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [e1_perf_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // receive line decoder, one strobe per bit
   input wire logic bit_strobe,
   input wire logic mark_pos,
   input wire logic mark_neg,
   // receive framer
   input wire logic crc_error,
   input wire logic e_bit_strobe,
   input wire logic e_bit_value,
   input wire logic fas_error,
   input wire logic frame_sync_lost,
   input wire logic crc_mf_sync_lost,
   // other status events, one-cycle pulses
   input wire logic rx_cas_multiframe_event,
   input wire logic rx_align_frame_event,
   input wire logic tx_multiframe_event,
   input wire logic tx_align_frame_event,
   input wire logic tx_clock_loss_event,
   input wire logic rx_crc_multiframe_event,
   input wire logic tx_elastic_slip_event,
   // interrupt
   output logic irq
);
   import e1_perf_pkg::*;

   logic [7:0] mask_q, control_q, status_q, status_d, set_vec;
   logic [31:0] tmr_q;
   logic tick, interval_sel, count_mode, hdb3_en;
   logic last_pol_q, have_mark_q, last_bpv_pol_q, have_bpv_q;
   logic [2:0] zeros_q;
   logic mark, bpv, hdb3_sub, cv, viol_event, crc_event, ebit_event, fas_event;
   logic [VIOL_W-1:0] viol_run_q, viol_rd_q;
   logic [CRC_W-1:0] crc_run_q, crc_rd_q;
   logic [EBIT_W-1:0] ebit_run_q, ebit_rd_q;
   logic [FAS_W-1:0] fas_run_q, fas_rd_q;
   logic aw_full_q, w_full_q, do_wr;
   logic [5:0] wr_idx, rd_idx;
   logic [7:0] wr_byte;
   logic rd_hit;
   logic [7:0] rd_byte;

   assign interval_sel = control_q[CTRL_INTERVAL_BIT];
   assign count_mode = control_q[CTRL_MODE_BIT];
   assign hdb3_en = control_q[CTRL_HDB3_BIT];

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ----------------------------------------------------------------
   // interval timer
   // ----------------------------------------------------------------
   // a change of interval select takes effect at the current count
   assign tick = interval_sel ? (tmr_q >= 32'(SHORT_CYCLES - 1))
                              : (tmr_q >= 32'(LONG_CYCLES - 1));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tmr_q <= 32'h0;
      end else if (tick) begin
         tmr_q <= 32'h0;
      end else begin
         tmr_q <= tmr_q + 32'h1;
      end
   end

   // ----------------------------------------------------------------
   // violation detection
   // ----------------------------------------------------------------
   // pos wins if the decoder ever flags both polarities at once
   assign mark = mark_pos | mark_neg;
   assign bpv = bit_strobe & mark & have_mark_q & (mark_pos == last_pol_q);
   // 000V or B00V: violation after three or two spaces is a substitution
   assign hdb3_sub = hdb3_en & ((zeros_q == 3'h3) | (zeros_q == 3'h2));
   assign cv = bpv & have_bpv_q & (mark_pos == last_bpv_pol_q);
   assign viol_event = count_mode ? cv : (bpv & ~hdb3_sub);

   // mark polarity and space run tracking
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_pol_q <= 1'b0;
         have_mark_q <= 1'b0;
         zeros_q <= 3'h0;
      end else if (bit_strobe) begin
         if (mark) begin
            last_pol_q <= mark_pos;
            have_mark_q <= 1'b1;
            zeros_q <= 3'h0;
         end else if (zeros_q != 3'h7) begin
            zeros_q <= zeros_q + 3'h1;
         end
      end
   end

   // polarity of the previous bipolar violation
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_bpv_pol_q <= 1'b0;
         have_bpv_q <= 1'b0;
      end else if (bpv) begin
         last_bpv_pol_q <= mark_pos;
         have_bpv_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // running counters and snapshots
   // ----------------------------------------------------------------
   assign crc_event = crc_error & ~frame_sync_lost & ~crc_mf_sync_lost;
   assign ebit_event = e_bit_strobe & ~e_bit_value
                       & ~frame_sync_lost & ~crc_mf_sync_lost;
   assign fas_event = fas_error & ~frame_sync_lost;

   // an event on the boundary cycle opens the next interval, so none is lost
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         viol_run_q <= '0;
         viol_rd_q <= '0;
      end else if (tick) begin
         viol_rd_q <= viol_run_q;
         viol_run_q <= VIOL_W'(viol_event);
      end else if (viol_event && viol_run_q != '1) begin
         viol_run_q <= viol_run_q + 16'h0001;
      end
   end

   // CRC4 word errors cannot reach the top in one second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         crc_run_q <= '0;
         crc_rd_q <= '0;
      end else if (tick) begin
         crc_rd_q <= crc_run_q;
         crc_run_q <= CRC_W'(crc_event);
      end else if (crc_event) begin
         crc_run_q <= crc_run_q + 10'h001;
      end
   end

   // far-end block errors from E bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ebit_run_q <= '0;
         ebit_rd_q <= '0;
      end else if (tick) begin
         ebit_rd_q <= ebit_run_q;
         ebit_run_q <= EBIT_W'(ebit_event);
      end else if (ebit_event) begin
         ebit_run_q <= ebit_run_q + 10'h001;
      end
   end

   // frame alignment word errors
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fas_run_q <= '0;
         fas_rd_q <= '0;
      end else if (tick) begin
         fas_rd_q <= fas_run_q;
         fas_run_q <= FAS_W'(fas_event);
      end else if (fas_event) begin
         fas_run_q <= fas_run_q + 12'h001;
      end
   end

   // ----------------------------------------------------------------
   // events, status and interrupt
   // ----------------------------------------------------------------
   assign set_vec = {rx_cas_multiframe_event, rx_align_frame_event, tx_multiframe_event,
                     tick, tx_align_frame_event, tx_clock_loss_event,
                     rx_crc_multiframe_event, tx_elastic_slip_event};

   // write one to clear; a set on the same cycle wins
   always_comb begin
      status_d = status_q;
      if (do_wr && wr_idx == IDX_STATUS && awaddr_q[1:0] == 2'h0) begin
         status_d = status_d & ~wr_byte;
      end
      status_d = status_d | set_vec;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_q <= 8'h00;
      end else begin
         status_q <= status_d;
      end
   end

   assign irq = |(status_q & mask_q);

   // ----------------------------------------------------------------
   // axi4-lite write side
   // ----------------------------------------------------------------
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   assign awready = ~aw_full_q & ~bvalid;
   assign wready = ~w_full_q & ~bvalid;
   assign do_wr = aw_full_q & w_full_q & ~bvalid;
   assign wr_idx = awaddr_q[7:2];
   // only the low byte lane carries register data
   assign wr_byte = wstrb_q[0] ? wdata_q[7:0] : 8'h00;

   // address and data are taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            aw_full_q <= 1'b1;
            awaddr_q <= awaddr;
         end else if (do_wr) begin
            aw_full_q <= 1'b0;
         end
         if (wvalid && wready) begin
            w_full_q <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end else if (do_wr) begin
            w_full_q <= 1'b0;
         end
      end
   end

   // write response; counts are read-only and accept writes silently
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (do_wr) begin
         bvalid <= 1'b1;
         bresp <= (awaddr_q[1:0] == 2'h0 && (wr_idx <= IDX_EBIT_LOW
                   || (wr_idx >= IDX_EVENT_MASK && wr_idx <= IDX_STATUS)))
                  ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // mask and control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_q <= MASK_RESET;
         control_q <= CONTROL_RESET;
      end else if (do_wr && wstrb_q[0] && awaddr_q[1:0] == 2'h0) begin
         if (wr_idx == IDX_EVENT_MASK) begin
            mask_q <= wdata_q[7:0];
         end
         if (wr_idx == IDX_CONTROL) begin
            control_q <= wdata_q[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read side
   // ----------------------------------------------------------------
   assign arready = ~rvalid;
   assign rd_idx = araddr[7:2];

   // shared bytes pack two counters, as the host expects
   always_comb begin
      rd_hit = araddr[1:0] == 2'h0;
      unique case (rd_idx)
         IDX_VIOL_HIGH: rd_byte = viol_rd_q[15:8];
         IDX_VIOL_LOW: rd_byte = viol_rd_q[7:0];
         IDX_FAS_CRC_HIGH: rd_byte = {fas_rd_q[11:6], crc_rd_q[9:8]};
         IDX_CRC_LOW: rd_byte = crc_rd_q[7:0];
         IDX_FAS_EBIT_MID: rd_byte = {fas_rd_q[5:0], ebit_rd_q[9:8]};
         IDX_EBIT_LOW: rd_byte = ebit_rd_q[7:0];
         IDX_EVENT_MASK: rd_byte = mask_q;
         IDX_CONTROL: rd_byte = control_q;
         IDX_STATUS: rd_byte = status_q;
         default: begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata <= {24'h0, rd_byte};
         rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence read_high_s;
      arvalid && arready && araddr == 8'h00;
   endsequence

   sequence boundary_s;
      tick ##1 1'b1;
   endsequence

   interval_snapshot_a: assert property (tick |=> viol_rd_q == $past(viol_run_q)
      && fas_rd_q == $past(fas_run_q) && crc_rd_q == $past(crc_run_q)
      && ebit_rd_q == $past(ebit_run_q))
      else $error("snapshot did not take running counts");
   snapshot_hold_a: assert property (!tick |=> $stable(viol_rd_q) && $stable(ebit_rd_q))
      else $error("snapshot changed between boundaries");
   timer_flag_a: assert property (boundary_s |-> status_q[EV_TIMER])
      else $error("timer flag missing after boundary");
   // the snapshot may move on the accepting edge, so compare with its value there
   read_high_a: assert property (read_high_s |=> rvalid
      && rdata[7:0] == $past(viol_rd_q[15:8]))
      else $error("violation high byte read wrong");
   bpv_count_a: assert property (!count_mode && bpv && !hdb3_sub && !tick
      && viol_run_q != 16'hFFFF |=> viol_run_q == $past(viol_run_q) + 16'h0001)
      else $error("bipolar violation not counted");
   hdb3_skip_a: assert property (!count_mode && hdb3_sub && !tick |=> $stable(viol_run_q))
      else $error("substitution violation counted");
   code_viol_a: assert property (count_mode && !cv && !tick |=> $stable(viol_run_q))
      else $error("non code violation counted");
   viol_sync_a: assert property (frame_sync_lost && viol_event && !tick
      && viol_run_q != 16'hFFFF |=> viol_run_q != $past(viol_run_q))
      else $error("violation counter stopped on sync loss");
   viol_saturate_a: assert property (viol_run_q == 16'hFFFF && !tick |=> viol_run_q == 16'hFFFF)
      else $error("violation counter wrapped");
   crc_halt_a: assert property ((frame_sync_lost || crc_mf_sync_lost) && !tick
      |=> $stable(crc_run_q) && $stable(ebit_run_q))
      else $error("crc or e-bit counted during sync loss");
   ebit_step_a: assert property (ebit_event && !tick |=> ebit_run_q == $past(ebit_run_q) + 10'h001)
      else $error("e-bit count did not step by one");
   fas_halt_a: assert property (frame_sync_lost && !tick |=> $stable(fas_run_q))
      else $error("fas counted during frame sync loss");
   mask_gate_a: assert property (tick && mask_q[EV_TIMER]
      && !(do_wr && wr_idx == IDX_EVENT_MASK) |=> irq)
      else $error("enabled timer event raised no interrupt");
   mask_block_a: assert property (mask_q == 8'h00 && !do_wr |=> !irq)
      else $error("masked events raised interrupt");

endmodule

/* verilog/e1_perf_pkg.sv */
package e1_perf_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_VIOL_HIGH = 6'h00;
   localparam logic [5:0] IDX_VIOL_LOW = 6'h01;
   localparam logic [5:0] IDX_FAS_CRC_HIGH = 6'h02;
   localparam logic [5:0] IDX_CRC_LOW = 6'h03;
   localparam logic [5:0] IDX_FAS_EBIT_MID = 6'h04;
   localparam logic [5:0] IDX_EBIT_LOW = 6'h05;
   localparam logic [5:0] IDX_EVENT_MASK = 6'h17;
   localparam logic [5:0] IDX_CONTROL = 6'h18;
   localparam logic [5:0] IDX_STATUS = 6'h19;
   localparam int ADDR_W = 8;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_INTERVAL_BIT = 7;
   localparam int CTRL_MODE_BIT = 6;
   localparam int CTRL_HDB3_BIT = 2;
   localparam int EV_RX_CAS_MF = 7;
   localparam int EV_RX_ALIGN = 6;
   localparam int EV_TX_MF = 5;
   localparam int EV_TIMER = 4;
   localparam int EV_TX_ALIGN = 3;
   localparam int EV_TX_CLK_LOSS = 2;
   localparam int EV_RX_CRC_MF = 1;
   localparam int EV_TX_SLIP = 0;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] CONTROL_RESET = 8'h00;

   // ----------------------------------------------------------------
   // counter widths and bus answers
   // ----------------------------------------------------------------
   localparam int VIOL_W = 16;
   localparam int CRC_W = 10;
   localparam int EBIT_W = 10;
   localparam int FAS_W = 12;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // interval timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int LONG_INTERVAL_US = 1000000;
   localparam int SHORT_INTERVAL_US = 62500;
   localparam int LONG_INTERVAL_CYCLES = LONG_INTERVAL_US * 1000 / CLK_PERIOD_NS;
   localparam int SHORT_INTERVAL_CYCLES = SHORT_INTERVAL_US * 1000 / CLK_PERIOD_NS;

endpackage

/* verification/e1_rx_framer_model.sv */
module e1_rx_framer_model (
   // clock
   input wire logic aclk,
   // line decoder side
   output logic bit_strobe,
   output logic mark_pos,
   output logic mark_neg,
   // framer errors and sync state
   output logic crc_error,
   output logic e_bit_strobe,
   output logic e_bit_value,
   output logic fas_error,
   output logic frame_sync_lost,
   output logic crc_mf_sync_lost,
   // status event pulses, bit 4 unused since the timer lives in the block
   output logic [7:0] ev
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // quiet line at start, framer in sync
   // ----------------------------------------------------------------
   initial begin
      bit_strobe = 1'b0;
      mark_pos = 1'b0;
      mark_neg = 1'b0;
      crc_error = 1'b0;
      e_bit_strobe = 1'b0;
      e_bit_value = 1'b1;
      fas_error = 1'b0;
      frame_sync_lost = 1'b0;
      crc_mf_sync_lost = 1'b0;
      ev = 8'h00;
   end

   // ----------------------------------------------------------------
   // stimulus tasks, all changes just after a rising edge
   // ----------------------------------------------------------------
   // symbols two bits each from the bottom: 0 space, 1 positive, 2 negative mark
   task automatic send_seq(input logic [31:0] syms, input int n, input int reps);
      for (int r = 0; r < reps; r++) begin
         for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            bit_strobe <= 1'b1;
            mark_pos <= (syms[2*i +: 2] == 2'h1);
            mark_neg <= (syms[2*i +: 2] == 2'h2);
         end
      end
      @(posedge aclk);
      bit_strobe <= 1'b0;
      mark_pos <= 1'b0;
      mark_neg <= 1'b0;
   endtask

   // kind 0 crc word error, 1 e bit zero, 2 e bit one, 3 fas word error
   task automatic pulse_err(input int kind, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge aclk);
         crc_error <= (kind == 0);
         e_bit_strobe <= (kind == 1) || (kind == 2);
         e_bit_value <= (kind == 2);
         fas_error <= (kind == 3);
         @(posedge aclk);
         crc_error <= 1'b0;
         e_bit_strobe <= 1'b0;
         e_bit_value <= !e_bit_value;
         fas_error <= 1'b0;
      end
   endtask

   // sync levels stay until changed again
   task automatic set_sync(input logic f, input logic c);
      @(posedge aclk);
      frame_sync_lost <= f;
      crc_mf_sync_lost <= c;
   endtask

   task automatic pulse_event(input int i);
      @(posedge aclk);
      ev[i] <= 1'b1;
      @(posedge aclk);
      ev <= 8'h00;
   endtask
endmodule

/* verification/e1_performance_error_counters_tb.sv */
module e1_performance_error_counters_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import e1_perf_pkg::*;

   // ----------------------------------------------------------------
   // signals, shortened intervals and register addresses
   // ----------------------------------------------------------------
   localparam int LONG = 70000;
   localparam int SHORT = 300;
   localparam logic [7:0] A_MASK = {IDX_EVENT_MASK, 2'b00};
   localparam logic [7:0] A_CTRL = {IDX_CONTROL, 2'b00};
   localparam logic [7:0] A_STAT = {IDX_STATUS, 2'b00};
   localparam logic [7:0] EXP_CNT [6] = '{8'h00, 8'h04, 8'h04, 8'h03, 8'h0C, 8'h02};
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs;
   logic bit_strobe, mark_pos, mark_neg, crc_error, e_bit_strobe, e_bit_value, fas_error;
   logic frame_sync_lost, crc_mf_sync_lost;
   logic [7:0] ev;
   int err_count, compares, cyc, t0, t1;

   e1_perf_counters #(.LONG_CYCLES(LONG), .SHORT_CYCLES(SHORT)) e1_perf_counters_i (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .bit_strobe, .mark_pos, .mark_neg, .crc_error, .e_bit_strobe, .e_bit_value,
      .fas_error, .frame_sync_lost, .crc_mf_sync_lost,
      .rx_cas_multiframe_event(ev[EV_RX_CAS_MF]), .rx_align_frame_event(ev[EV_RX_ALIGN]),
      .tx_multiframe_event(ev[EV_TX_MF]), .tx_align_frame_event(ev[EV_TX_ALIGN]),
      .tx_clock_loss_event(ev[EV_TX_CLK_LOSS]), .rx_crc_multiframe_event(ev[EV_RX_CRC_MF]),
      .tx_elastic_slip_event(ev[EV_TX_SLIP]), .irq);

   e1_rx_framer_model e1_rx_framer_model_i (
      .aclk, .bit_strobe, .mark_pos, .mark_neg, .crc_error, .e_bit_strobe, .e_bit_value,
      .fas_error, .frame_sync_lost, .crc_mf_sync_lost, .ev);

   // 100 MHz clock and a free cycle count for interval spacing
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) cyc <= cyc + 1;

   // ----------------------------------------------------------------
   // compare, bus and closing tasks
   // ----------------------------------------------------------------
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t resp got=%h exp=%h", $time, got, exp);
      end
   endtask

   // address and data offered together, each dropped once taken
   task automatic axi_write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h0, d};
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 60);
      bready <= 1'b0;
      r = bresp;
      if (n >= 60) err_count++;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 60);
      rready <= 1'b0;
      d = rdata;
      r = rresp;
      if (n >= 60) err_count++;
   endtask

   task automatic wr_ok(input logic [7:0] a, input logic [7:0] d);
      axi_write(a, d, rs);
      chk_resp(rs, RESP_OKAY);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      axi_read(a, rd, rs);
      chk_val(rd, e);
      chk_resp(rs, er);
   endtask

   // waits for the timer interrupt, notes the cycle, then clears the flag
   task automatic wait_tick(output int t);
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (irq !== 1'b1 && n < 80000);
      t = cyc;
      if (n >= 80000) err_count++;
      wr_ok(A_STAT, 8'h10);
   endtask

   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // watchdog: the full run needs about 72700 cycles
   initial begin
      repeat (90000) @(posedge aclk);
      err_count++;
      stop_test();
   end

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      err_count = 0;
      compares = 0;
      cyc = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      // switch to short intervals early, while the long timer is still young
      wr_ok(A_CTRL, 8'h80);
      for (int i = 0; i < 6; i++) rd_chk(8'(i * 4), 32'h0, RESP_OKAY);
      rd_chk(A_CTRL, 32'h80, RESP_OKAY);
      rd_chk(8'h18, 32'h0, RESP_SLVERR);
      axi_write(8'h5D, 8'hFF, rs);
      chk_resp(rs, RESP_SLVERR);
      rd_chk(A_MASK, {24'h0, MASK_RESET}, RESP_OKAY);
      wr_ok(8'h04, 8'hAA);
      rd_chk(8'h04, 32'h0, RESP_OKAY);
      // every event but the timer, enabled then cleared one by one
      wr_ok(A_MASK, 8'hEF);
      rd_chk(A_MASK, 32'hEF, RESP_OKAY);
      for (int i = 0; i < 8; i++) begin
         if (i != EV_TIMER) begin
            e1_rx_framer_model_i.pulse_event(i);
            @(posedge aclk);
            chk_val({31'h0, irq}, 32'h1);
            wr_ok(A_STAT, 8'(1 << i));
            chk_val({31'h0, irq}, 32'h0);
         end
      end
      // a masked event is still recorded but raises nothing
      wr_ok(A_MASK, 8'h00);
      e1_rx_framer_model_i.pulse_event(EV_RX_CAS_MF);
      @(posedge aclk);
      chk_val({31'h0, irq}, 32'h0);
      axi_read(A_STAT, rd, rs);
      chk_val(rd & 32'h80, 32'h80);
      wr_ok(A_STAT, 8'hFF);
      wr_ok(A_MASK, 8'h10);
      wait_tick(t0);
      wait_tick(t1);
      chk_val(32'(t1 - t0), 32'(SHORT));
      // one interval of mixed errors, part of it with sync lost
      e1_rx_framer_model_i.send_seq(32'h295, 5, 1);
      e1_rx_framer_model_i.pulse_err(0, 3);
      e1_rx_framer_model_i.pulse_err(1, 2);
      e1_rx_framer_model_i.pulse_err(2, 1);
      e1_rx_framer_model_i.pulse_err(3, 66);
      e1_rx_framer_model_i.set_sync(1'b1, 1'b0);
      for (int k = 0; k < 4; k++) e1_rx_framer_model_i.pulse_err(k, 1);
      e1_rx_framer_model_i.send_seq(32'h29, 3, 1);
      e1_rx_framer_model_i.set_sync(1'b0, 1'b1);
      for (int k = 0; k < 4; k++) e1_rx_framer_model_i.pulse_err(k, 1);
      e1_rx_framer_model_i.set_sync(1'b0, 1'b0);
      wait_tick(t0);
      for (int i = 0; i < 6; i++) begin
         rd_chk(8'(i * 4), {24'h0, EXP_CNT[i]}, RESP_OKAY);
      end
      wait_tick(t0);
      rd_chk(8'h04, 32'h0, RESP_OKAY);
      // substitution words after two and three spaces are skipped
      wr_ok(A_CTRL, 8'h84);
      wait_tick(t0);
      e1_rx_framer_model_i.send_seq(32'hA0901, 10, 1);
      wait_tick(t0);
      rd_chk(8'h04, 32'h1, RESP_OKAY);
      // code violation counting, the suggested choice for an hdb3 line
      wr_ok(A_CTRL, 8'hC4);
      wait_tick(t0);
      e1_rx_framer_model_i.send_seq(32'h55A5, 8, 1);
      wait_tick(t0);
      rd_chk(8'h04, 32'h2, RESP_OKAY);
      // long interval carrying more violations than the counter can hold
      wait_tick(t0);
      wr_ok(A_CTRL, 8'h00);
      e1_rx_framer_model_i.send_seq(32'h1, 1, 65541);
      wait_tick(t1);
      chk_val(32'(t1 - t0), 32'(LONG));
      rd_chk(8'h00, 32'hFF, RESP_OKAY);
      rd_chk(8'h04, 32'hFF, RESP_OKAY);
      stop_test();
   end
endmodule
